// File: verilog/supply_drop_pkg.sv
// Package of register offsets, field positions and reset values for the supply supervisor.
package supply_drop_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [3:0] OFF_CONFIG = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h1;
  localparam logic [3:0] OFF_EVENT  = 4'h2;
  localparam logic [3:0] OFF_MASK   = 4'h3;

  // Configuration field positions.
  localparam int unsigned CFG_PWRD_BIT  = 0;
  localparam int unsigned CFG_RSTD_BIT  = 1;
  localparam int unsigned CFG_STOP_BIT  = 2;
  localparam int unsigned CFG_RANGE_BIT = 3;

  // Status field position.
  localparam int unsigned STAT_FLAG_BIT = 7;

  // Event bit positions.
  localparam int unsigned EV_DROP_BIT = 0;
  localparam int unsigned EV_RISE_BIT = 1;

  // Reset values.
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic       RANGE_RESET  = 1'b0;

endpackage : supply_drop_pkg

// File: verilog/trip_hysteresis.sv
// Hysteresis latch that turns the two comparator outputs into a low-supply flag.
module trip_hysteresis (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  // Comparator results and enable
  input  wire logic i_enable,
  input  wire logic i_below_fall,
  input  wire logic i_above_rise,
  // Flag
  output logic      o_low
);

  logic low_d;
  logic low_q;

  // Below the falling threshold sets, above the rising one clears, in between holds.
  assign low_d = !i_enable     ? 1'b0 :
                 i_below_fall  ? 1'b1 :
                 i_above_rise  ? 1'b0 : low_q;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_q <= 1'b0;
    end else begin
      low_q <= low_d;
    end
  end

  assign o_low = low_q;

endmodule : trip_hysteresis

// File: verilog/supply_drop_reset_control.sv
// Control logic of the supply supervisor: configuration, hysteresis, reset request and status.
module supply_drop_reset_control (
  // Clock and resets
  input  wire logic                                i_clk,
  input  wire logic                                i_reset_n,
  input  wire logic                                i_por_n,
  // Analog comparator, already resolved for the selected range
  input  wire logic                                i_below_fall,
  input  wire logic                                i_above_rise,
  // Low-power mode indications
  input  wire logic                                i_wait_mode,
  input  wire logic                                i_stop_mode,
  // Register port
  input  wire logic [supply_drop_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [supply_drop_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                                i_wr,
  input  wire logic                                i_rd,
  output logic      [supply_drop_pkg::DATA_W-1:0]  o_rdata,
  // Supervisor outputs
  output logic                                     o_range_high,
  output logic                                     o_monitor_on,
  output logic                                     o_reset_req,
  output logic                                     o_rst_pin_n,
  output logic                                     o_rst_pin_oe,
  output logic                                     o_low_supply,
  output logic                                     o_irq
);

  localparam int unsigned DW = supply_drop_pkg::DATA_W;

  // Address decode shared by the write enables and the read checks.
  function automatic logic reg_hit(input logic [supply_drop_pkg::ADDR_W-1:0] addr,
                                   input logic [supply_drop_pkg::ADDR_W-1:0] off);
    return addr == off;
  endfunction : reg_hit

  logic [DW-1:0] cfg_q;
  logic          range_q;
  logic [DW-1:0] event_q;
  logic [DW-1:0] event_d;
  logic [DW-1:0] mask_q;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rdata_d;
  logic          rst_q;
  logic          rst_d;
  logic          low_flag;
  logic          low_prev_q;
  logic          range_prev_q;
  logic          range_rise;

  wire wr_cfg   = i_wr && reg_hit(i_addr, supply_drop_pkg::OFF_CONFIG);
  wire wr_event = i_wr && reg_hit(i_addr, supply_drop_pkg::OFF_EVENT);
  wire wr_mask  = i_wr && reg_hit(i_addr, supply_drop_pkg::OFF_MASK);

  wire pwrd     = cfg_q[supply_drop_pkg::CFG_PWRD_BIT];
  wire rstd     = cfg_q[supply_drop_pkg::CFG_RSTD_BIT];
  wire stop_en  = cfg_q[supply_drop_pkg::CFG_STOP_BIT];

  // Stop mode silences the supervisor unless stop operation is enabled; wait mode never does.
  wire active   = !pwrd && !(i_stop_mode && !stop_en);

  // Comparator is ignored entirely while inactive.
  wire below    = active && i_below_fall;
  wire above    = active && i_above_rise;

  // A raise of the range is judged one cycle after the write, once the comparator reports
  // against the new thresholds; in the write cycle it still answers for the lower range.
  assign range_rise = range_q && !range_prev_q;

  // Reset starts on a drop or on a range raise with the supply not above the new rising
  // point, and then holds until the supply is reported above the rising point.
  assign rst_d = !active || rstd      ? 1'b0 :
                 below                ? 1'b1 :
                 range_rise && !above ? 1'b1 :
                 rst_q && !above      ? 1'b1 :
                 1'b0;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_q <= supply_drop_pkg::CONFIG_RESET;
      rst_q <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg_q <= i_wdata;
      end
      rst_q <= rst_d;
    end
  end

  // Range select survives ordinary resets; only power-on reset restores the low range.
  always_ff @(posedge i_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      range_q <= supply_drop_pkg::RANGE_RESET;
    end else if (wr_cfg) begin
      range_q <= i_wdata[supply_drop_pkg::CFG_RANGE_BIT];
    end
  end

  // The edge detector shares the power-on reset of the range, so no ordinary reset
  // can make a false raise appear.
  always_ff @(posedge i_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      range_prev_q <= supply_drop_pkg::RANGE_RESET;
    end else begin
      range_prev_q <= range_q;
    end
  end

  trip_hysteresis u_hyst (
    .i_clk        (i_clk),
    .i_reset_n    (i_reset_n),
    .i_enable     (active),
    .i_below_fall (i_below_fall),
    .i_above_rise (i_above_rise),
    .o_low        (low_flag)
  );

  // Event status for the system interrupt controller; this is not a processor
  // interrupt of the supervisor itself, just a record of drops and recoveries.
  wire ev_drop = low_flag && !low_prev_q;
  wire ev_rise = !low_flag && low_prev_q;

  // Set wins over the write-one-to-clear in the same cycle.
  always_comb begin
    event_d = event_q;
    if (wr_event) begin
      event_d = event_q & ~i_wdata;
    end
    event_d[supply_drop_pkg::EV_DROP_BIT] = event_d[supply_drop_pkg::EV_DROP_BIT] | ev_drop;
    event_d[supply_drop_pkg::EV_RISE_BIT] = event_d[supply_drop_pkg::EV_RISE_BIT] | ev_rise;
    event_d[DW-1:2] = '0;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      event_q    <= '0;
      mask_q     <= supply_drop_pkg::MASK_RESET;
      low_prev_q <= 1'b0;
    end else begin
      event_q    <= event_d;
      low_prev_q <= low_flag;
      if (wr_mask) begin
        mask_q <= i_wdata;
      end
    end
  end

  always_comb begin
    rdata_d = '0;
    if (i_rd) begin
      case (i_addr)
        supply_drop_pkg::OFF_CONFIG: rdata_d = {cfg_q[DW-1:4], range_q, cfg_q[2:0]};
        supply_drop_pkg::OFF_STATUS: rdata_d[supply_drop_pkg::STAT_FLAG_BIT] = low_flag;
        supply_drop_pkg::OFF_EVENT:  rdata_d = event_q;
        supply_drop_pkg::OFF_MASK:   rdata_d = mask_q;
        default:                     rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata      = rdata_q;
  assign o_range_high = range_q;
  assign o_monitor_on = active;
  assign o_reset_req  = rst_q;
  assign o_rst_pin_n  = 1'b0;
  assign o_rst_pin_oe = rst_q;
  assign o_low_supply = low_flag;
  assign o_irq        = |(event_q & mask_q);

  // Assertions. The steps of the hysteresis reset are named once and reused below.
  sequence s_armed;
    active && !rstd;
  endsequence

  sequence s_drop;
    active && !rstd && i_below_fall;
  endsequence

  sequence s_between;
    active && !rstd && !i_below_fall && !i_above_rise;
  endsequence

  sequence s_recover;
    active && i_above_rise && !i_below_fall;
  endsequence

  a_drop_starts_reset: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    s_drop |=> o_reset_req)
    else $error("drop did not start reset");

  a_reset_holds_hyst: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    s_armed ##0 (o_reset_req && !i_above_rise) |=> o_reset_req)
    else $error("reset released early");

  a_drop_then_hold: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    s_drop ##1 s_between |=> o_reset_req)
    else $error("reset lost between the thresholds");

  a_recover_releases: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    s_recover |=> !o_reset_req)
    else $error("reset kept after recovery");

  a_disabled_no_reset: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    pwrd |=> !o_reset_req)
    else $error("reset while monitoring disabled");

  a_rstd_blocks_reset: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    $past(rstd) && rstd |-> !o_reset_req)
    else $error("reset while resets disabled");

  a_pin_follows_req: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    o_rst_pin_oe == o_reset_req && !o_rst_pin_n)
    else $error("reset pin mismatch");

  a_flag_sets_low: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (active && i_below_fall) |=> o_low_supply)
    else $error("flag not set on drop");

  a_flag_clears_high: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (active && !i_below_fall && i_above_rise) |=> !o_low_supply)
    else $error("flag not cleared");

  a_flag_holds_mid: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (active && !i_below_fall && !i_above_rise) |=> $stable(o_low_supply))
    else $error("flag moved");

  a_inactive_flag_clear: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !active |=> !o_low_supply)
    else $error("flag set while monitoring inactive");

  a_status_readback: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_rd && reg_hit(i_addr, supply_drop_pkg::OFF_STATUS)) |=> o_rdata[supply_drop_pkg::STAT_FLAG_BIT] == $past(low_flag))
    else $error("status read does not show the flag");

  a_stop_silences: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_stop_mode && !stop_en) |-> !o_monitor_on)
    else $error("active in stop without enable");

  a_stop_keeps_on: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_stop_mode && stop_en && !pwrd) |-> o_monitor_on)
    else $error("inactive in stop with enable");

  a_wait_keeps_on: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_wait_mode && !i_stop_mode && !pwrd) |-> o_monitor_on)
    else $error("inactive in wait mode");

  a_power_off_idle: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    pwrd |-> !o_monitor_on)
    else $error("monitoring on while powered down");

  a_range_high_reset: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    s_armed ##0 (range_rise && !i_above_rise) |=> o_reset_req)
    else $error("no reset on range raise");

  a_range_write_lands: assert property (
    @(posedge i_clk) disable iff (!i_por_n)
    wr_cfg |=> o_range_high == $past(i_wdata[supply_drop_pkg::CFG_RANGE_BIT]))
    else $error("range select did not take the write");

  a_range_por_low: assert property (
    @(posedge i_clk)
    !i_por_n |=> !o_range_high)
    else $error("range select survived power-on reset");

  a_enabled_after_reset: assert property (
    @(posedge i_clk)
    $rose(i_reset_n) |-> !pwrd)
    else $error("supervisor not enabled after reset");

endmodule : supply_drop_reset_control

// File: dv/supply_comparator_model.sv
// Behavioural supply comparator that resolves a supply level in millivolts.
module supply_comparator_model #(
  parameter int FALL_LO = 2600,
  parameter int RISE_LO = 2700,
  parameter int FALL_HI = 4300,
  parameter int RISE_HI = 4400
) (
  input  var  int   i_mv,
  input  wire logic i_range_high,
  output logic      o_below_fall,
  output logic      o_above_rise
);
  timeunit 1ns;
  timeprecision 1ns;
  // Both trips move with the range, so a range change alone can flip the outputs.
  assign o_below_fall = i_mv < (i_range_high ? FALL_HI : FALL_LO);
  assign o_above_rise = i_mv > (i_range_high ? RISE_HI : RISE_LO);
endmodule : supply_comparator_model

// File: dv/tb_top.sv
// Self-checking bench for the supply supervisor control logic.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       i_clk, i_reset_n, i_por_n, i_below_fall, i_above_rise;
  logic       i_wait_mode, i_stop_mode, i_wr, i_rd;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  logic       o_range_high, o_monitor_on, o_reset_req, o_rst_pin_n, o_rst_pin_oe, o_low_supply, o_irq;
  int         mv, num_errors, n_compared;
  wire  [7:0] outs = {1'b0, o_rst_pin_n, o_range_high, o_monitor_on, o_reset_req, o_rst_pin_oe, o_low_supply, o_irq};

  supply_drop_reset_control dut (.i_clk, .i_reset_n, .i_por_n, .i_below_fall, .i_above_rise, .i_wait_mode,
    .i_stop_mode, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_range_high, .o_monitor_on, .o_reset_req,
    .o_rst_pin_n, .o_rst_pin_oe, .o_low_supply, .o_irq);
  supply_comparator_model cmp (.i_mv(mv), .i_range_high(o_range_high), .o_below_fall(i_below_fall),
    .o_above_rise(i_above_rise));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask : rdchk

  // Two edges: one for the flag and reset request to register, one for the event bits that follow them.
  task automatic sup(input int v);
    @(posedge i_clk);
    mv <= v;
    repeat (2) @(posedge i_clk);
    #1;
  endtask : sup

  task automatic rst(input logic por);
    @(posedge i_clk);
    i_reset_n <= 1'b0; i_por_n <= ~por;
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1; i_por_n <= 1'b1;
    sup(mv);
  endtask : rst

  task automatic t_defaults;
    chk(outs, 8'h10);
    rdchk(supply_drop_pkg::OFF_CONFIG, supply_drop_pkg::CONFIG_RESET);
    rdchk(supply_drop_pkg::OFF_MASK, supply_drop_pkg::MASK_RESET);
    wr(supply_drop_pkg::OFF_STATUS, 8'hff);
    rdchk(supply_drop_pkg::OFF_STATUS, 8'h00);
    rdchk(4'hf, 8'h00);
  endtask : t_defaults

  task automatic t_forced;
    sup(2500); chk(outs, 8'h1e);
    rdchk(supply_drop_pkg::OFF_STATUS, 8'h80);
    sup(2650); chk(outs, 8'h1e);
    sup(2800); chk(outs, 8'h10);
    sup(2650); chk(outs, 8'h10);
    wr(supply_drop_pkg::OFF_CONFIG, 8'h02);
    sup(2500); chk(outs, 8'h12);
    sup(2800); chk(outs, 8'h10);
  endtask : t_forced

  task automatic t_disable;
    wr(supply_drop_pkg::OFF_CONFIG, 8'h01);
    sup(2500); chk(outs, 8'h00);
    wr(supply_drop_pkg::OFF_CONFIG, 8'h00);
    sup(2500); chk(outs, 8'h1e);
    sup(2800);
  endtask : t_disable

  task automatic t_modes;
    @(posedge i_clk) i_wait_mode <= 1'b1;
    sup(2500); chk(outs, 8'h1e);
    sup(2800);
    @(posedge i_clk) begin
      i_wait_mode <= 1'b0;
      i_stop_mode <= 1'b1;
    end
    sup(2500); chk(outs, 8'h00);
    wr(supply_drop_pkg::OFF_CONFIG, 8'h04);
    sup(2500); chk(outs, 8'h1e);
    sup(2800);
    @(posedge i_clk) i_stop_mode <= 1'b0;
  endtask : t_modes

  task automatic t_range;
    wr(supply_drop_pkg::OFF_CONFIG, 8'h00);
    sup(4350); chk(outs, 8'h10);
    wr(supply_drop_pkg::OFF_CONFIG, 8'h08);
    sup(4350); chk(outs, 8'h3c);
    sup(3500); chk(outs, 8'h3e);
    sup(4500); chk(outs, 8'h30);
    rst(1'b0); chk(outs, 8'h30);
    rdchk(supply_drop_pkg::OFF_CONFIG, 8'h08);
    rst(1'b1); chk(outs, 8'h10);
  endtask : t_range

  task automatic t_events;
    wr(supply_drop_pkg::OFF_MASK, 8'h01);
    sup(2500); chk(outs, 8'h1f);
    sup(2800); chk(outs, 8'h11);
    rdchk(supply_drop_pkg::OFF_EVENT, 8'h03);
    wr(supply_drop_pkg::OFF_EVENT, 8'h01);
    sup(2800); chk(outs, 8'h10);
    wr(supply_drop_pkg::OFF_MASK, 8'h02);
    sup(2800); chk(outs, 8'h11);
    wr(supply_drop_pkg::OFF_EVENT, 8'h02);
    sup(2800); chk(outs, 8'h10);
  endtask : t_events

  task automatic conclude;
    $display("compared %0d, mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  initial begin
    {i_reset_n, i_por_n, i_wait_mode, i_stop_mode, i_wr, i_rd, i_addr, i_wdata} = '0;
    mv = 3300;
    num_errors = 0;
    n_compared = 0;
    rst(1'b1);
    t_defaults();
    t_forced();
    t_disable();
    t_modes();
    t_range();
    t_events();
    conclude();
  end

  // The whole sequence takes under 150 cycles; this span leaves a wide margin.
  initial begin
    #100us;
    num_errors++;
    conclude();
  end
endmodule : tb_top
